// ---- verilog/ispg_params.svh ----
/*
 * Timing constants and configuration defaults for the index and sector pulse generator.
 * Assumes a 100 MHz system clock; included by the package and the design module.
 */
`ifndef ISPG_PARAMS_SVH
`define ISPG_PARAMS_SVH

`define ISPG_CLK_PERIOD_NS 10
`define ISPG_INDEX_PULSE_NS 4000
`define ISPG_INDEX_PULSE_CYC ((`ISPG_INDEX_PULSE_NS + `ISPG_CLK_PERIOD_NS - 1) / `ISPG_CLK_PERIOD_NS)
`define ISPG_SEEN_CLR_NS 100
`define ISPG_SEEN_CLR_CYC ((`ISPG_SEEN_CLR_NS + `ISPG_CLK_PERIOD_NS - 1) / `ISPG_CLK_PERIOD_NS)
`define ISPG_LOAD_PULSE_NS 350
`define ISPG_LOAD_PULSE_CYC ((`ISPG_LOAD_PULSE_NS + `ISPG_CLK_PERIOD_NS - 1) / `ISPG_CLK_PERIOD_NS)
`define ISPG_CNT_WIDTH 12
`define ISPG_SECTOR_LOAD_DEFAULT 12'h2a0
`define ISPG_PULSE_CNT_WIDTH 10

`endif

// ---- verilog/ispg_pkg.sv ----
/*
 * Types shared by the index and sector pulse generator.
 * Assumes ispg_params.svh is on the include path.
 */
`include "ispg_params.svh"

package ispg_pkg;

  // index detector flop set
  typedef struct packed {
    logic pulse_seen;
    logic missing_pulse;
    logic stage_one;
    logic stage_two;
    logic stage_three;
  } ispg_det_s;

  // raw timing inputs from the servo clock divider
  typedef struct packed {
    logic servo_gap_pulse;
    logic servo_divided_clock;
    logic byte_clock;
  } ispg_tim_s;

  typedef enum logic [1:0] {
    ISPG_SEC_OFF,
    ISPG_SEC_WAIT_INDEX,
    ISPG_SEC_RUN
  } ispg_sec_e;

endpackage

// ---- verilog/ispg_gen.sv ----
/*
 * Index and sector pulse generator: a missing-dibit index detector and a
 * strap-programmed sector down-counter, both emitting status pulses.
 * Assumes the timing inputs are synchronous to i_mclk and much slower than it.
 */
// Contract
// [R1] index marker is three missing servo gap pulses with gap pulses between them, once per revolution
// [R2] each detected marker gives one 4 us index pulse
// [R3] servo clock rise starts 100 ns clear of pulse seen; gap pulse sets it
// [R4] missing pulse flop clocked by servo clock, set if no gap pulse, off unloaded
// [R5] stage flops advance on gap pulses after missing intervals
// [R6] index gate when missing,!one,two,three; output pulse starts at gate release
// [R7] heads not loaded holds all detector flops cleared
// [R8] reverse rotation or random dropouts never match the gate
// [R9] 12-bit down-counter with fixed strap-programmed load value
// [R10] counter loaded by 350 ns pulse at every index and sector leading edge
// [R11] decrement on byte clock; zero sets sector flop and reloads; clear next interval
// [R12] sector enable held reset while load speed is active
// [R13] first index after load speed drops enables sectoring; each index reloads
// [R14] higher-density load value is bytes per sector over 1.5, modulus 4096
// [R15] one-shots are counters; servo and gap clocks are edge-detected
`timescale 1ns/1ps
`include "ispg_params.svh"

module ispg_gen #(
  parameter int CNT_WIDTH = `ISPG_CNT_WIDTH,
  parameter logic [`ISPG_CNT_WIDTH-1:0] SECTOR_LOAD = `ISPG_SECTOR_LOAD_DEFAULT
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire ispg_pkg::ispg_tim_s i_tim,
  input wire logic i_heads_loaded,
  input wire logic i_load_speed_active,
  output logic o_index_pulse,
  output logic o_sector_pulse
);
  import ispg_pkg::*;

  // the strap value and the zero detect are built for a 12-bit counter only
  if (CNT_WIDTH != `ISPG_CNT_WIDTH) begin : g_bad_width
    $error("ispg_gen: counter width must be 12");
  end

  localparam logic [`ISPG_PULSE_CNT_WIDTH-1:0] IDX_CYC = `ISPG_PULSE_CNT_WIDTH'(`ISPG_INDEX_PULSE_CYC);
  localparam logic [`ISPG_PULSE_CNT_WIDTH-1:0] CLR_CYC = `ISPG_PULSE_CNT_WIDTH'(`ISPG_SEEN_CLR_CYC);
  localparam logic [`ISPG_PULSE_CNT_WIDTH-1:0] LD_CYC = `ISPG_PULSE_CNT_WIDTH'(`ISPG_LOAD_PULSE_CYC);
  localparam logic [`ISPG_PULSE_CNT_WIDTH-1:0] ONE = `ISPG_PULSE_CNT_WIDTH'(1);

  ////////////////////////////////////////////////////////////////////////////
  // edge detection of the slow timing inputs

  ispg_tim_s tim_d_r;
  logic gap_rise;
  logic srv_rise;
  logic byte_fall;
  logic byte_rise;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tim_d_r <= '0;
    end else begin
      tim_d_r <= i_tim;
    end
  end

  assign gap_rise = i_tim.servo_gap_pulse & ~tim_d_r.servo_gap_pulse; // [R15]
  assign srv_rise = i_tim.servo_divided_clock & ~tim_d_r.servo_divided_clock; // [R15]
  assign byte_fall = ~i_tim.byte_clock & tim_d_r.byte_clock; // [R15]
  assign byte_rise = i_tim.byte_clock & ~tim_d_r.byte_clock; // [R15]

  ////////////////////////////////////////////////////////////////////////////
  // index detector

  ispg_det_s det_r;
  logic [`ISPG_PULSE_CNT_WIDTH-1:0] clr_cnt_r;
  logic gate;
  logic gate_d_r;

  // clear one-shot for pulse seen
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clr_cnt_r <= '0;
    end else if (srv_rise) begin
      clr_cnt_r <= CLR_CYC; // [R3] [R15]
    end else if (clr_cnt_r != '0) begin
      clr_cnt_r <= clr_cnt_r - ONE;
    end
  end

  // pulse seen: gap rise sets, clear pulse resets
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      det_r.pulse_seen <= 1'b0;
    end else if (!i_heads_loaded) begin
      det_r.pulse_seen <= 1'b0; // [R7]
    end else if (gap_rise) begin
      det_r.pulse_seen <= 1'b1; // [R3]
    end else if (clr_cnt_r != '0) begin
      det_r.pulse_seen <= 1'b0; // [R3]
    end
  end

  // missing pulse flop: sampled on servo clock rise
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      det_r.missing_pulse <= 1'b0;
    end else if (!i_heads_loaded) begin
      det_r.missing_pulse <= 1'b0; // [R4] [R7]
    end else if (srv_rise) begin
      det_r.missing_pulse <= ~det_r.pulse_seen; // [R1] [R4]
    end
  end

  // stage shift on gap pulses: one takes missing, two takes one, three takes two
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      det_r.stage_one <= 1'b0;
      det_r.stage_two <= 1'b0;
      det_r.stage_three <= 1'b0;
    end else if (!i_heads_loaded) begin
      det_r.stage_one <= 1'b0; // [R7]
      det_r.stage_two <= 1'b0; // [R7]
      det_r.stage_three <= 1'b0; // [R7]
    end else if (gap_rise) begin
      det_r.stage_one <= det_r.missing_pulse; // [R5]
      det_r.stage_two <= det_r.stage_one; // [R5]
      det_r.stage_three <= det_r.stage_two; // [R5]
    end
  end

  // asymmetric match only: reversed or random dropouts leave a stage wrong
  assign gate = det_r.missing_pulse & ~det_r.stage_one & det_r.stage_two & det_r.stage_three; // [R6] [R8]

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gate_d_r <= 1'b0;
    end else begin
      gate_d_r <= gate;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // index one-shot, started on gate release

  logic [`ISPG_PULSE_CNT_WIDTH-1:0] idx_cnt_r;
  logic idx_start;

  // a gate cut by heads unloading is not a release
  assign idx_start = gate_d_r & ~gate & i_heads_loaded; // [R6] [R7]

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_cnt_r <= '0;
      o_index_pulse <= 1'b0;
    end else if (idx_start) begin
      idx_cnt_r <= IDX_CYC - ONE; // [R2]
      o_index_pulse <= 1'b1; // [R2]
    end else if (idx_cnt_r != '0) begin
      idx_cnt_r <= idx_cnt_r - ONE;
    end else begin
      o_index_pulse <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sector enable

  ispg_sec_e sec_st_r;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sec_st_r <= ISPG_SEC_OFF;
    end else if (i_load_speed_active) begin
      sec_st_r <= ISPG_SEC_OFF; // [R12]
    end else begin
      case (sec_st_r)
        ISPG_SEC_OFF: begin
          sec_st_r <= ISPG_SEC_WAIT_INDEX;
        end
        ISPG_SEC_WAIT_INDEX: begin
          if (idx_start) begin
            sec_st_r <= ISPG_SEC_RUN; // [R13]
          end
        end
        ISPG_SEC_RUN: begin
          sec_st_r <= ISPG_SEC_RUN;
        end
        default: begin
          sec_st_r <= ISPG_SEC_OFF;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sector counter and load one-shot

  logic [CNT_WIDTH-1:0] sec_cnt_r;
  logic [`ISPG_PULSE_CNT_WIDTH-1:0] ld_cnt_r;
  logic sec_hit;
  logic sec_flag_r;

  // load value is a strap constant; higher-density drives use bytes/1.5
  assign sec_hit = (sec_st_r == ISPG_SEC_RUN) && (ld_cnt_r == '0) && (sec_cnt_r == '0) && byte_fall; // [R11] [R14]

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ld_cnt_r <= '0;
    end else if (idx_start || sec_hit) begin
      ld_cnt_r <= LD_CYC; // [R10] [R13]
    end else if (ld_cnt_r != '0) begin
      ld_cnt_r <= ld_cnt_r - ONE;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sec_cnt_r <= '0;
    end else if (ld_cnt_r != '0) begin
      sec_cnt_r <= SECTOR_LOAD; // [R9] [R10]
    end else if (byte_rise && sec_cnt_r != '0) begin
      // leading edge counts, trailing edge of the same pulse fires the sector
      sec_cnt_r <= sec_cnt_r - 1'b1; // [R11]
    end
  end

  // sector flop: set on zero, cleared at the next byte clock fall
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sec_flag_r <= 1'b0;
    end else if (sec_st_r != ISPG_SEC_RUN) begin
      sec_flag_r <= 1'b0; // [R12]
    end else if (sec_hit) begin
      sec_flag_r <= 1'b1; // [R11]
    end else if (byte_fall) begin
      sec_flag_r <= 1'b0; // [R11]
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sector_pulse <= 1'b0;
    end else begin
      o_sector_pulse <= sec_flag_r;
    end
  end

endmodule

// ---- verif/ispg_gen_sva.sv ----
/*
 * Concurrent checks on the index and sector pulse ports.
 * Assumes the 100 MHz clock and the active-low asynchronous reset of the design.
 */
`timescale 1ns/1ps
module ispg_gen_sva (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire ispg_pkg::ispg_tim_s i_tim,
  input wire logic i_heads_loaded,
  input wire logic i_load_speed_active,
  input wire logic o_index_pulse,
  input wire logic o_sector_pulse
);
  import ispg_pkg::*;
  logic [9:0] hi_r;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hi_r <= 10'h000;
    end else begin
      hi_r <= o_index_pulse ? hi_r + 10'h001 : 10'h000;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence sec_hold_s;
    o_sector_pulse [*8];
  endsequence
  sequence byte_fell_s;
    $past(i_tim.byte_clock, 4) && !i_tim.byte_clock;
  endsequence
  idx_width_a: assert property ($fell(o_index_pulse) |-> hi_r == 10'h190)
    else $error("index pulse width wrong");
  idx_max_a: assert property (hi_r <= 10'h190)
    else $error("index pulse too long");
  idx_loaded_a: assert property ($rose(o_index_pulse) |-> $past(i_heads_loaded, 3))
    else $error("index while heads unloaded");
  idx_gap_a: assert property ($rose(o_index_pulse) |-> $past(i_tim.servo_gap_pulse, 2))
    else $error("index not started by gap pulse");
  sec_ls_a: assert property ($rose(o_sector_pulse) |-> !$past(i_load_speed_active, 3))
    else $error("sector during load speed");
  sec_rise_a: assert property ($rose(o_sector_pulse) |-> byte_fell_s)
    else $error("sector not on byte clock fall");
  sec_fall_a: assert property (($fell(o_sector_pulse) && !$past(i_load_speed_active, 3)) |-> byte_fell_s)
    else $error("sector not cleared on byte clock fall");
  sec_min_a: assert property ($rose(o_sector_pulse) |-> sec_hold_s)
    else $error("sector pulse too short");
  rst_quiet_a: assert property ($rose(i_rst_n) |-> !o_index_pulse && !o_sector_pulse)
    else $error("pulse out of reset");
endmodule
bind ispg_gen ispg_gen_sva u_sva (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_tim(i_tim),
  .i_heads_loaded(i_heads_loaded), .i_load_speed_active(i_load_speed_active),
  .o_index_pulse(o_index_pulse), .o_sector_pulse(o_sector_pulse));

// ---- verif/ispg_ctrl_model.sv ----
/*
 * Controller side: counts index and sector pulses and times sector spacing.
 * Assumes pulses are synchronous to the system clock.
 */
`timescale 1ns/1ps
module ispg_ctrl_model (
  input wire logic i_mclk,
  input wire logic i_index_pulse,
  input wire logic i_sector_pulse,
  output int o_n_index,
  output int o_n_sector,
  output int o_sec_gap
);
  logic idx_d;
  logic sec_d;
  int t;
  int t_last;
  initial begin
    {idx_d, sec_d} = 2'b00;
    {o_n_index, o_n_sector, o_sec_gap, t, t_last} = '0;
  end
  always @(posedge i_mclk) begin
    t <= t + 1;
    idx_d <= i_index_pulse;
    sec_d <= i_sector_pulse;
    if (i_index_pulse === 1'b1 && idx_d === 1'b0) o_n_index <= o_n_index + 1;
    if (i_sector_pulse === 1'b1 && sec_d === 1'b0) begin
      o_n_sector <= o_n_sector + 1;
      o_sec_gap <= t - t_last;
      t_last <= t;
    end
  end
endmodule

// ---- verif/tb.sv ----
/*
 * Self-checking bench: servo gap patterns and byte clock into the generator.
 * Assumes a short strap load value so sectors come quickly.
 */
`timescale 1ns/1ps
module tb;
  import ispg_pkg::*;
  localparam int BYTE_CYC = 124;
  localparam int SERVO_CYC = 248;
  localparam logic [11:0] LOAD = 12'h004;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  ispg_tim_s tim = '0;
  logic hl = 1'b1;
  logic ls = 1'b1;
  logic idx;
  logic sec;
  int n_idx, n_sec, sec_gap, s0;
  int n_fail = 0;
  int checks_done = 0;
  int bc = 0;
  always #5 i_mclk = ~i_mclk;
  ispg_gen #(.SECTOR_LOAD(LOAD)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_tim(tim),
    .i_heads_loaded(hl), .i_load_speed_active(ls), .o_index_pulse(idx), .o_sector_pulse(sec));
  ispg_ctrl_model u_ctrl (.i_mclk(i_mclk), .i_index_pulse(idx), .i_sector_pulse(sec),
    .o_n_index(n_idx), .o_n_sector(n_sec), .o_sec_gap(sec_gap));
  always @(posedge i_mclk) begin
    bc <= (bc + 1) % BYTE_CYC;
    tim.byte_clock <= (bc < BYTE_CYC / 2);
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // n servo intervals, bits of p taken MSB first, gap pulse present when the bit is set
  task automatic pat(input logic [11:0] p, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      tim.servo_divided_clock <= 1'b1;
      repeat (SERVO_CYC / 2) @(posedge i_mclk);
      tim.servo_divided_clock <= 1'b0;
      tim.servo_gap_pulse <= p[i];
      repeat (5) @(posedge i_mclk);
      tim.servo_gap_pulse <= 1'b0;
      repeat (SERVO_CYC / 2 - 5) @(posedge i_mclk);
    end
  endtask
  ////////////////////////////////////////
  task automatic t_marker();
    s0 = n_idx;
    pat(12'h1ad, 9);
    chk(n_idx - s0, 1);
    chk(n_sec, 0);
  endtask
  task automatic t_dropout();
    s0 = n_idx;
    pat(12'hef5, 12);
    pat(12'h6d7, 11);
    chk(n_idx - s0, 0);
  endtask
  task automatic t_unloaded();
    hl <= 1'b0;
    s0 = n_idx;
    pat(12'h1ad, 9);
    chk(n_idx - s0, 0);
    hl <= 1'b1;
  endtask
  task automatic t_sector();
    int w;
    ls <= 1'b0;
    repeat (2000) @(posedge i_mclk);
    chk(n_sec, 0);
    pat(12'h1ad, 9);
    repeat (BYTE_CYC * 20) @(posedge i_mclk);
    chk(n_sec > 2, 1);
    chk(sec_gap, BYTE_CYC * LOAD);
    // raise load speed between sector pulses so none is cut short
    w = 0;
    while (sec !== 1'b1 && w < 1000) begin
      @(posedge i_mclk);
      w++;
    end
    while (sec !== 1'b0 && w < 1000) begin
      @(posedge i_mclk);
      w++;
    end
    chk(w < 1000, 1);
    if (w >= 1000) final_report();
    ls <= 1'b1;
    repeat (10) @(posedge i_mclk);
    s0 = n_sec;
    repeat (2000) @(posedge i_mclk);
    chk(n_sec - s0, 0);
  endtask
  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    @(posedge i_mclk);
    pat(12'hfff, 3);
    t_marker();
    t_dropout();
    t_unloaded();
    t_sector();
    final_report();
  end
endmodule
